// file: src/acc_pkg.sv
// acc_pkg: shared constants for the calibration correction block
package acc_pkg;

    // ------------------------------------------------------------
    // register byte offsets on the apb bus
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_CTRL_OFF    = 8'h00;
    localparam logic [7:0] ACC_SYSOFS_OFF  = 8'h04;
    localparam logic [7:0] ACC_SYSGAIN_OFF = 8'h08;
    localparam logic [7:0] ACC_SELFOFS_OFF = 8'h0C;
    localparam logic [7:0] ACC_DATA_OFF    = 8'h10;
    localparam logic [7:0] ACC_SER_OFF     = 8'h14;

    // ------------------------------------------------------------
    // control register fields and reset values
    // ------------------------------------------------------------
    localparam int         ACC_FMT_BIT       = 0;
    localparam int         ACC_SELF_DIS_BIT  = 1;
    localparam int         ACC_SYSO_DIS_BIT  = 2;
    localparam int         ACC_SYSG_DIS_BIT  = 3;
    localparam int         ACC_TGT_LSB       = 4;
    localparam int         ACC_WCNT_LSB      = 8;
    localparam int         ACC_RCNT_LSB      = 16;
    localparam logic       ACC_FMT_RST       = 1'h0;
    localparam logic       ACC_DIS_RST       = 1'h1;
    localparam logic [1:0] ACC_TGT_SYSOFS    = 2'h0;
    localparam logic [1:0] ACC_TGT_SYSGAIN   = 2'h1;
    localparam logic [1:0] ACC_TGT_SELFOFS   = 2'h2;
    localparam logic [23:0] ACC_COEF_RST     = 24'h000000;

    // ------------------------------------------------------------
    // datapath constants
    // ------------------------------------------------------------
    localparam logic [4:0]          ACC_COEF_LAST = 5'h17;
    localparam logic signed [24:0]  ACC_GAIN_ONE  = 25'sh0800000;
    localparam int                  ACC_GAIN_SH   = 23;
    localparam int                  ACC_CODE_SH   = 6;
    localparam logic signed [50:0]  ACC_CODE_MAX  = 51'sh000000001FFFF;
    localparam logic signed [50:0]  ACC_CODE_MIN  = 51'sh7FFFFFFFE0000;
    localparam logic [17:0]         ACC_CODE_POS  = 18'h1FFFF;
    localparam logic [17:0]         ACC_CODE_NEG  = 18'h20000;
    localparam logic [17:0]         ACC_CODE_MSB  = 18'h20000;

    typedef enum logic {
        ACC_PH_IDLE = 1'b0,
        ACC_PH_RESP = 1'b1
    } acc_ph_t;

endpackage

// file: src/acc_core.sv
// acc_core: calibration correction datapath, coefficient store and apb slave
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - offset binary: 0x3FFFF top, 0x20000 zero, 0x1FFFF below zero, 0x00000 bottom
// - two's complement: 0x1FFFF top, 0x00000 zero, 0x3FFFF below zero, 0x20000 bottom
// - format bit 0 selects two's complement, 1 selects offset binary
// - out-of-range results clamp to the extreme codes, never wrap
// - 24-bit system offset coefficient, read/write, two's complement, resets to zero
// - coefficients shift in and out most significant bit first
// - system coefficients persist until rewritten or system calibration replaces them
// - system offset subtracted only while its disable bit is 0
// - system offset applied after self corrections and before system gain
// - system offset applied before the bipolar/unipolar scale factor; the code has only the bipolar 1x scale, no unipolar mode
// - 24-bit system gain coefficient, read/write, two's complement, resets to zero
// - system gain applied only while its disable bit is 0
// - system gain scales from 0 up to 2x
// - residual gain error after correction at most 2 LSB
// - 24-bit self offset coefficient, read/write, two's complement, resets to zero
// - self offset persists until rewritten or self calibration replaces it
// - self offset subtracted only while its disable bit is 0
// - self offset is the first correction step
// - self offset applied before the unipolar 2x scale factor; the code has no unipolar mode, only the bipolar 1x scale
module acc_core
    import acc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // raw conversion input
    input  wire logic        conv_valid,
    input  wire logic [23:0] conv_data,
    // calibration sequencer results
    input  wire logic        sys_cal_done,
    input  wire logic [23:0] sys_cal_offset,
    input  wire logic [23:0] sys_cal_gain,
    input  wire logic        self_cal_done,
    input  wire logic [23:0] self_cal_offset,
    // corrected result
    output logic             result_valid,
    output logic      [17:0] result_code
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        acc_ph_t     ph;
        logic [23:0] sys_ofs;
        logic [23:0] sys_gain;
        logic [23:0] self_ofs;
        logic        fmt;
        logic        self_dis;
        logic        syso_dis;
        logic        sysg_dis;
        logic [1:0]  tgt;
        logic [23:0] shreg;
        logic [4:0]  wcnt;
        logic [4:0]  rcnt;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        rvalid;
        logic [17:0] code;
    } acc_state_t;

    acc_state_t st_r;
    acc_state_t st_nxt;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [23:0] coef_of(input acc_state_t s, input logic [1:0] t);
        case (t)
            ACC_TGT_SYSOFS:  coef_of = s.sys_ofs;
            ACC_TGT_SYSGAIN: coef_of = s.sys_gain;
            ACC_TGT_SELFOFS: coef_of = s.self_ofs;
            default:      coef_of = ACC_COEF_RST;
        endcase
    endfunction

    function automatic logic [17:0] fmt_code(input logic signed [50:0] v,
                                              input logic ofs_bin);
        logic signed [50:0] sh;
        logic [17:0]        c;
        sh = v >>> ACC_CODE_SH;
        if (sh > ACC_CODE_MAX) begin
            c = ACC_CODE_POS;
        end else if (sh < ACC_CODE_MIN) begin
            c = ACC_CODE_NEG;
        end else begin
            c = sh[17:0];
        end
        // offset binary is two's complement with the sign bit inverted
        fmt_code = ofs_bin ? (c ^ ACC_CODE_MSB) : c;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic               acc_req;
    logic               wr_go;
    logic               rd_go;
    logic               mapped;
    logic [23:0]        cur_coef;
    logic signed [25:0] acc;
    logic signed [24:0] gfac;
    logic        [50:0] prod;
    logic signed [50:0] val;

    always_comb begin
        st_nxt   = st_r;
        acc_req  = psel && penable;
        wr_go    = acc_req && pwrite && (st_r.ph == ACC_PH_RESP);
        rd_go    = acc_req && !pwrite && (st_r.ph == ACC_PH_RESP);
        mapped   = (paddr == ACC_CTRL_OFF) || (paddr == ACC_SYSOFS_OFF) ||
                   (paddr == ACC_SYSGAIN_OFF) || (paddr == ACC_SELFOFS_OFF) ||
                   (paddr == ACC_DATA_OFF) || (paddr == ACC_SER_OFF);
        cur_coef = coef_of(st_r, st_r.tgt);
        acc      = 26'(signed'(conv_data));
        gfac     = ACC_GAIN_ONE;
        prod     = 51'h0;
        val      = 51'h0;

        // bus phases: answer registered one cycle into access, act on the ready edge
        case (st_r.ph)
            ACC_PH_IDLE: begin
                st_nxt.pready  = 1'b0;
                st_nxt.pslverr = 1'b0;
                if (acc_req) begin
                    st_nxt.ph      = ACC_PH_RESP;
                    st_nxt.pready  = 1'b1;
                    st_nxt.pslverr = !mapped;
                    st_nxt.prdata  = 32'h00000000;
                    if (!pwrite) begin
                        case (paddr)
                            ACC_CTRL_OFF: begin
                                st_nxt.prdata[ACC_FMT_BIT]      = st_r.fmt;
                                st_nxt.prdata[ACC_SELF_DIS_BIT] = st_r.self_dis;
                                st_nxt.prdata[ACC_SYSO_DIS_BIT] = st_r.syso_dis;
                                st_nxt.prdata[ACC_SYSG_DIS_BIT] = st_r.sysg_dis;
                                st_nxt.prdata[ACC_TGT_LSB +: 2] = st_r.tgt;
                                st_nxt.prdata[ACC_WCNT_LSB +: 5] = st_r.wcnt;
                                st_nxt.prdata[ACC_RCNT_LSB +: 5] = st_r.rcnt;
                            end
                            ACC_SYSOFS_OFF:  st_nxt.prdata[23:0] = st_r.sys_ofs;
                            ACC_SYSGAIN_OFF: st_nxt.prdata[23:0] = st_r.sys_gain;
                            ACC_SELFOFS_OFF: st_nxt.prdata[23:0] = st_r.self_ofs;
                            ACC_DATA_OFF: st_nxt.prdata[17:0] = st_r.code;
                            // next bit of the selected coefficient, top bit first
                            ACC_SER_OFF:  st_nxt.prdata[0] =
                                cur_coef[ACC_COEF_LAST - st_r.rcnt];
                            default:      st_nxt.prdata = 32'h00000000;
                        endcase
                    end
                end
            end
            ACC_PH_RESP: begin
                st_nxt.ph     = ACC_PH_IDLE;
                st_nxt.pready = 1'b0;
            end
            default: begin
                st_nxt.ph     = ACC_PH_IDLE;
                st_nxt.pready = 1'b0;
            end
        endcase

        if (wr_go) begin
            case (paddr)
                ACC_CTRL_OFF: begin
                    st_nxt.fmt      = pwdata[ACC_FMT_BIT];
                    st_nxt.self_dis = pwdata[ACC_SELF_DIS_BIT];
                    st_nxt.syso_dis = pwdata[ACC_SYSO_DIS_BIT];
                    st_nxt.sysg_dis = pwdata[ACC_SYSG_DIS_BIT];
                    st_nxt.tgt      = pwdata[ACC_TGT_LSB +: 2];
                    // a control write restarts both serial transfers
                    st_nxt.wcnt     = 5'h00;
                    st_nxt.rcnt     = 5'h00;
                end
                ACC_SYSOFS_OFF:  st_nxt.sys_ofs  = pwdata[23:0];
                ACC_SYSGAIN_OFF: st_nxt.sys_gain = pwdata[23:0];
                ACC_SELFOFS_OFF: st_nxt.self_ofs = pwdata[23:0];
                ACC_SER_OFF: begin
                    st_nxt.shreg = {st_r.shreg[22:0], pwdata[0]};
                    if (st_r.wcnt == ACC_COEF_LAST) begin
                        st_nxt.wcnt = 5'h00;
                        case (st_r.tgt)
                            ACC_TGT_SYSOFS:  st_nxt.sys_ofs  = {st_r.shreg[22:0], pwdata[0]};
                            ACC_TGT_SYSGAIN: st_nxt.sys_gain = {st_r.shreg[22:0], pwdata[0]};
                            ACC_TGT_SELFOFS: st_nxt.self_ofs = {st_r.shreg[22:0], pwdata[0]};
                            default:      st_nxt.shreg = st_r.shreg;
                        endcase
                    end else begin
                        st_nxt.wcnt = st_r.wcnt + 5'h01;
                    end
                end
                default: st_nxt.shreg = st_r.shreg;
            endcase
        end
        if (rd_go && (paddr == ACC_SER_OFF)) begin
            st_nxt.rcnt = (st_r.rcnt == ACC_COEF_LAST) ? 5'h00 : st_r.rcnt + 5'h01;
        end

        // a finished calibration overwrites whatever the host wrote
        if (sys_cal_done) begin
            st_nxt.sys_ofs  = sys_cal_offset;
            st_nxt.sys_gain = sys_cal_gain;
        end
        if (self_cal_done) begin
            st_nxt.self_ofs = self_cal_offset;
        end

        // correction chain, self offset first, system gain last
        if (!st_r.self_dis) begin
            acc = acc - 26'(signed'(st_r.self_ofs));
        end
        if (!st_r.syso_dis) begin
            acc = acc - 26'(signed'(st_r.sys_ofs));
        end
        // bipolar scale is 1x, so nothing follows the offsets here
        val = 51'(acc);
        if (!st_r.sysg_dis) begin
            // factor is 1 + coef/2^23: zero coefficient leaves the gain at 1x
            gfac = ACC_GAIN_ONE + 25'(signed'(st_r.sys_gain));
            prod = {{25{acc[25]}}, acc} * {{26{gfac[24]}}, gfac};
            // truncation after the shift keeps the error under one code
            val  = signed'(prod) >>> ACC_GAIN_SH;
        end
        st_nxt.rvalid = conv_valid;
        if (conv_valid) begin
            st_nxt.code = fmt_code(val, st_r.fmt);
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r          <= '0;
            st_r.ph       <= ACC_PH_IDLE;
            st_r.sys_ofs  <= ACC_COEF_RST;
            st_r.sys_gain <= ACC_COEF_RST;
            st_r.self_ofs <= ACC_COEF_RST;
            st_r.fmt      <= ACC_FMT_RST;
            st_r.self_dis <= ACC_DIS_RST;
            st_r.syso_dis <= ACC_DIS_RST;
            st_r.sysg_dis <= ACC_DIS_RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign prdata       = st_r.prdata;
    assign pready       = st_r.pready;
    assign pslverr      = st_r.pslverr;
    assign result_valid = st_r.rvalid;
    assign result_code  = st_r.code;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking acc_cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    logic all_dis;
    assign all_dis = st_r.self_dis && st_r.syso_dis && st_r.sysg_dis;

    a_ofs_zero_code: assert property (
        (ce && conv_valid && all_dis && st_r.fmt && conv_data == 24'h000000)
        |=> result_code == 18'h20000)
        else $error("offset binary zero code wrong");

    a_twos_top_code: assert property (
        (ce && conv_valid && all_dis && !st_r.fmt && conv_data == 24'h7FFFFF)
        |=> result_code == 18'h1FFFF)
        else $error("two's complement top code wrong");

    a_gain_clamp_top: assert property (
        (ce && conv_valid && st_r.self_dis && st_r.syso_dis && !st_r.sysg_dis
         && st_r.sys_gain == 24'h200000 && conv_data == 24'h7F0000 && st_r.fmt)
        |=> result_code == 18'h3FFFF)
        else $error("overrange result wrapped");

    a_ofs_apb_write: assert property (
        (ce && st_r.ph == ACC_PH_RESP && psel && penable && pwrite
         && paddr == ACC_SYSOFS_OFF && !sys_cal_done)
        |=> st_r.sys_ofs == $past(pwdata[23:0]))
        else $error("system offset write lost");

    a_ser_msb_first: assert property (
        (ce && st_r.ph == ACC_PH_IDLE && psel && penable && !pwrite
         && paddr == ACC_SER_OFF && st_r.rcnt == 5'h00 && st_r.tgt == ACC_TGT_SYSGAIN)
        |=> prdata[0] == $past(st_r.sys_gain[23]) && pready)
        else $error("serial read not msb first");

    a_sys_cal_load: assert property (
        (ce && sys_cal_done) |=> st_r.sys_ofs == $past(sys_cal_offset)
        && st_r.sys_gain == $past(sys_cal_gain))
        else $error("system calibration not loaded");

    a_sys_ofs_subtract: assert property (
        (ce && conv_valid && !st_r.syso_dis && st_r.self_dis && st_r.sysg_dis
         && !st_r.fmt && conv_data == st_r.sys_ofs)
        |=> result_code == 18'h00000)
        else $error("system offset not subtracted");

    a_self_ofs_subtract: assert property (
        (ce && conv_valid && !st_r.self_dis && st_r.syso_dis && st_r.sysg_dis
         && !st_r.fmt && conv_data == st_r.self_ofs)
        |=> result_code == 18'h00000)
        else $error("self offset not subtracted");

    a_self_cal_load: assert property (
        (ce && self_cal_done) |=> st_r.self_ofs == $past(self_cal_offset))
        else $error("self calibration not loaded");

    a_partial_hold: assert property (
        (ce && st_r.ph == ACC_PH_RESP && psel && penable && pwrite
         && paddr == ACC_SER_OFF && st_r.wcnt != ACC_COEF_LAST && !sys_cal_done
         && !self_cal_done)
        |=> $stable(st_r.sys_ofs) && $stable(st_r.sys_gain) && $stable(st_r.self_ofs))
        else $error("partial serial write changed a coefficient");

    a_ready_single: assert property (
        pready |=> !pready || !ce)
        else $error("pready held longer than one cycle");

    c_serial_commit: cover property (
        ce && wr_go && paddr == ACC_SER_OFF && st_r.wcnt == ACC_COEF_LAST);
    c_gain_used: cover property (ce && conv_valid && !st_r.sysg_dis);
    c_unmapped: cover property (pready && pslverr);

endmodule

`default_nettype wire

// file: tb/acc_host_model.sv
// host model: apb master that issues single register transfers
`timescale 1ns/1ps
`default_nettype none
module acc_host_model (
    // clock
    input  wire logic        sys_clk,
    // apb master side
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic tmo;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h00000000;
        tmo     = 1'b0;
    end

    // ------------------------------------------------------------
    // one transfer; caller enters just after a rising edge
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int i;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) tmo = 1'b1;
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // stale write data must not look valid once released
        pwdata  <= ~d;
        // idle edge so the next setup never lands on this release
        @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// file: tb/adc_calibration_correction_tb_top.sv
// testbench: coefficient registers, serial port and corrected codes
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module adc_calibration_correction_tb_top
    import acc_pkg::*;
;
    logic        sys_clk, sys_rst, ce, conv_valid, sys_cal_done, self_cal_done;
    logic [23:0] conv_data, sys_cal_offset, sys_cal_gain, self_cal_offset, v, r;
    logic        psel, penable, pwrite, pready, pslverr, result_valid, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [17:0] result_code;
    logic [5:0]  ctl;
    logic [23:0] cf [3];
    logic [7:0]  offs [3] = '{ACC_SYSOFS_OFF, ACC_SYSGAIN_OFF, ACC_SELFOFS_OFF};
    logic [23:0] pr [4] = '{24'h000000, 24'hFFFFC0, 24'h7FFFFF, 24'h800000};
    logic [17:0] pe [4] = '{18'h00000, 18'h3FFFF, 18'h1FFFF, 18'h20000};
    // last two raw values equal the offsets so a lone enabled offset yields zero
    logic [23:0] cr [5] = '{24'h123456, 24'h7F0000, 24'h810000, 24'h001234, 24'hFFF100};
    int          error_cnt, n_tests, i, k, f;

    always #4 sys_clk = ~sys_clk;

    acc_host_model host (.sys_clk(sys_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    acc_core dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_valid(conv_valid),
        .conv_data(conv_data), .sys_cal_done(sys_cal_done),
        .sys_cal_offset(sys_cal_offset), .sys_cal_gain(sys_cal_gain),
        .self_cal_done(self_cal_done), .self_cal_offset(self_cal_offset),
        .result_valid(result_valid), .result_code(result_code));

    // ------------------------------------------------------------
    // reference arithmetic and helpers
    // ------------------------------------------------------------
    function automatic logic [17:0] expc(input logic [23:0] raw);
        longint a;
        a = longint'($signed(raw));
        if (!ctl[1]) a = a - longint'($signed(cf[2]));
        if (!ctl[2]) a = a - longint'($signed(cf[0]));
        if (!ctl[3]) a = (a * (64'sh800000 + longint'($signed(cf[1])))) >>> 23;
        a = a >>> 6;
        if (a > 64'sh1FFFF) a = 64'sh1FFFF;
        if (a < -64'sh20000) a = -64'sh20000;
        return a[17:0] ^ {ctl[0], 17'h00000};
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
        host.xfer(w, a, d, q, e);
        if (host.tmo === 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
    endtask

    task automatic setctl(input logic [5:0] c);
        ctl = c;
        rw(1'b1, ACC_CTRL_OFF, {26'h0000000, c});
    endtask

    task automatic chkcoef();
        for (int j = 0; j < 3; j++) begin
            rw(1'b0, offs[j], 32'h00000000);
            `CHK("coef read", {8'h00, cf[j]}, q)
        end
    endtask

    // raw result in, one-cycle answer checked; code left for the caller
    task automatic conv(input logic [23:0] raw);
        conv_valid <= 1'b1;
        conv_data  <= raw;
        @(posedge sys_clk);
        conv_valid <= 1'b0;
        conv_data  <= ~raw;
        #1;
        `CHK("result_valid", 1'b1, result_valid)
        @(posedge sys_clk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        ce = 1'b1;
        conv_valid = 1'b0;
        conv_data = 24'h000000;
        sys_cal_done = 1'b0;
        self_cal_done = 1'b0;
        sys_cal_offset = 24'h00ABCD;
        sys_cal_gain = 24'hF00000;
        self_cal_offset = 24'h000321;
        error_cnt = 0;
        n_tests = 0;
        cf = '{24'h000000, 24'h000000, 24'h000000};
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rw(1'b0, ACC_CTRL_OFF, 32'h00000000);
        `CHK("ctrl reset", 32'h0000000E, q)
        chkcoef();
        rw(1'b0, 8'h18, 32'h00000000);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h00000000, q)
        for (f = 0; f < 2; f++) begin
            setctl(6'h0E | 6'(f));
            for (k = 0; k < 4; k++) begin
                conv(pr[k]);
                `CHK("format point", pe[k] ^ {f[0], 17'h00000}, result_code)
            end
        end
        cf = '{24'h001234, 24'h200000, 24'hFFF100};
        for (i = 0; i < 3; i++) rw(1'b1, offs[i], {8'hFF, cf[i]});
        for (i = 0; i < 16; i++) begin
            setctl({2'h3, 4'(i)});
            for (k = 0; k < 5; k++) begin
                conv(cr[k]);
                `CHK("corrected", expc(cr[k]), result_code)
            end
        end
        rw(1'b1, ACC_DATA_OFF, 32'h0003FFFF);
        rw(1'b0, ACC_DATA_OFF, 32'h00000000);
        `CHK("data reg", {14'h0000, expc(cr[4])}, q)
        chkcoef();
        // serial write, msb first, into the system gain slot
        v = 24'hA5C3E1;
        setctl(6'h1E);
        for (i = 23; i >= 0; i--) begin
            rw(1'b1, ACC_SER_OFF, {31'h00000000, v[i]});
            if (i == 1) chkcoef();
        end
        cf[1] = v;
        chkcoef();
        setctl(6'h1E);
        r = 24'h000000;
        for (i = 0; i < 24; i++) begin
            rw(1'b0, ACC_SER_OFF, 32'h00000000);
            r = {r[22:0], q[0]};
        end
        `CHK("serial read", v, r)
        sys_cal_done <= 1'b1;
        self_cal_done <= 1'b1;
        @(posedge sys_clk);
        sys_cal_done <= 1'b0;
        self_cal_done <= 1'b0;
        cf = '{24'h00ABCD, 24'hF00000, 24'h000321};
        chkcoef();
        setctl(6'h30);
        conv(24'h3C0000);
        `CHK("calibrated", expc(24'h3C0000), result_code)
        report_and_stop();
    end
endmodule
`default_nettype wire
